/* File: shared/uecm_params.svh */
`ifndef UECM_PARAMS_SVH
`define UECM_PARAMS_SVH

`define UECM_NUM_EP        5
`define UECM_ADDR_W        8
`define UECM_DATA_W        8
`define UECM_CNT_W         6
`define UECM_EP_W          3

// Endpoint register addresses on the CPU I/O port
`define UECM_ADDR_CNT0     8'h11
`define UECM_ADDR_MODE0    8'h12
`define UECM_ADDR_CNT1     8'h13
`define UECM_ADDR_MODE1    8'h14
`define UECM_ADDR_CNT2     8'h15
`define UECM_ADDR_MODE2    8'h16
`define UECM_ADDR_CNT3     8'h41
`define UECM_ADDR_MODE3    8'h42
`define UECM_ADDR_CNT4     8'h43
`define UECM_ADDR_MODE4    8'h44

// Count register fields
`define UECM_CNT_TOG       7
`define UECM_CNT_VALID     6
`define UECM_CNT_RST       8'h00
`define UECM_RX_ZLP_CNT    6'h02

// Mode register fields
`define UECM_MODE_SETUP    7
`define UECM_MODE_IN       6
`define UECM_MODE_OUT      5
`define UECM_MODE_ACK      4
`define UECM_MODE_STALL    7
`define UECM_MODE_RST      8'h00

// Mode encodings
`define UECM_M_DISABLE     4'h0
`define UECM_M_NAK_INOUT   4'h1
`define UECM_M_STAT_OUT    4'h2
`define UECM_M_STALL_IO    4'h3
`define UECM_M_IGN_IO      4'h4
`define UECM_M_ISO_OUT     4'h5
`define UECM_M_STAT_IN     4'h6
`define UECM_M_ISO_IN      4'h7
`define UECM_M_NAK_OUT     4'h8
`define UECM_M_ACK_OUT     4'h9
`define UECM_M_NAK_OUT_SI  4'hA
`define UECM_M_ACK_OUT_SI  4'hB
`define UECM_M_NAK_IN      4'hC
`define UECM_M_ACK_IN      4'hD
`define UECM_M_NAK_IN_SO   4'hE
`define UECM_M_ACK_IN_SO   4'hF

`endif

/* File: shared/uecm_pkg.sv */
package uecm_pkg;
	typedef enum logic [1:0] {
		UECM_PID_SETUP = 2'h0,
		UECM_PID_IN    = 2'h1,
		UECM_PID_OUT   = 2'h2,
		UECM_PID_NONE  = 2'h3
	} uecm_pid_t;

	typedef enum logic [2:0] {
		UECM_R_IGNORE = 3'h0,
		UECM_R_ACK    = 3'h1,
		UECM_R_NAK    = 3'h2,
		UECM_R_STALL  = 3'h3,
		UECM_R_TXCNT  = 3'h4,
		UECM_R_TX0    = 3'h5,
		UECM_R_CHECK  = 3'h6
	} uecm_resp_t;

	typedef enum logic [0:0] {
		UECM_ST_IDLE = 1'h0,
		UECM_ST_BUSY = 1'h1
	} uecm_state_t;
endpackage : uecm_pkg

/* File: shared/uecm_lock_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface uecm_lock_if;
	logic mode_upd;
	logic cnt_upd;
	logic mode_rd;
	logic cnt_rd;
	logic mode_lock;
	logic cnt_lock;
	modport owner (input mode_upd, cnt_upd, mode_rd, cnt_rd, output mode_lock, cnt_lock);
	modport user  (output mode_upd, cnt_upd, mode_rd, cnt_rd, input mode_lock, cnt_lock);
endinterface : uecm_lock_if
`default_nettype wire

/* File: verilog/uecm_ep0_lock.sv */
`timescale 1ns/1ps
`default_nettype none
module uecm_ep0_lock (
	input  wire logic   i_clk,
	input  wire logic   i_rst_b,
	uecm_lock_if.owner  lk
);
	logic mode_lock_ff;
	logic cnt_lock_ff;

	// RL22 single mode flag
	// RL10 update beats read
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_lock_ff <= 1'b0;
		end else if (lk.mode_upd) begin
			mode_lock_ff <= 1'b1;
		end else if (lk.mode_rd) begin
			mode_lock_ff <= 1'b0;
		end
	end

	// RL7 count lock flag
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_lock_ff <= 1'b0;
		end else if (lk.cnt_upd) begin
			cnt_lock_ff <= 1'b1;
		end else if (lk.cnt_rd) begin
			cnt_lock_ff <= 1'b0;
		end
	end

	assign lk.mode_lock = mode_lock_ff;
	assign lk.cnt_lock  = cnt_lock_ff;
endmodule : uecm_ep0_lock
`default_nettype wire

/* File: verilog/uecm_mode_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uecm_params.svh"
module uecm_mode_decode (
	input  wire logic [3:0]          i_mode,
	input  wire logic                i_stall,
	input  wire uecm_pkg::uecm_pid_t i_pid,
	input  wire logic                i_acked,
	output uecm_pkg::uecm_resp_t     o_resp,
	output logic [3:0]               o_nxt_mode
);
	logic setup_ok;

	// RL13 setup accepting modes
	always_comb begin
		case (i_mode)
			`UECM_M_NAK_INOUT, `UECM_M_STAT_OUT, `UECM_M_STALL_IO, `UECM_M_IGN_IO,
			`UECM_M_STAT_IN, `UECM_M_NAK_OUT_SI, `UECM_M_ACK_OUT_SI,
			`UECM_M_NAK_IN_SO, `UECM_M_ACK_IN_SO: setup_ok = 1'b1;
			default: setup_ok = 1'b0;
		endcase
	end

	always_comb begin
		o_resp = uecm_pkg::UECM_R_IGNORE;
		if (i_pid == uecm_pkg::UECM_PID_SETUP) begin
			o_resp = setup_ok ? uecm_pkg::UECM_R_ACK : uecm_pkg::UECM_R_IGNORE;
		end else if (i_pid == uecm_pkg::UECM_PID_IN) begin
			case (i_mode)
				// RL14 nak in/out
				`UECM_M_NAK_INOUT, `UECM_M_NAK_IN, `UECM_M_NAK_IN_SO: o_resp = uecm_pkg::UECM_R_NAK;
				`UECM_M_STAT_OUT, `UECM_M_STALL_IO: o_resp = uecm_pkg::UECM_R_STALL;
				`UECM_M_STAT_IN, `UECM_M_NAK_OUT_SI, `UECM_M_ACK_OUT_SI: o_resp = uecm_pkg::UECM_R_TX0;
				`UECM_M_ISO_IN, `UECM_M_ACK_IN_SO: o_resp = uecm_pkg::UECM_R_TXCNT;
				// RL17 stall gates ack in
				`UECM_M_ACK_IN: o_resp = i_stall ? uecm_pkg::UECM_R_STALL : uecm_pkg::UECM_R_TXCNT;
				default: o_resp = uecm_pkg::UECM_R_IGNORE;
			endcase
		end else if (i_pid == uecm_pkg::UECM_PID_OUT) begin
			case (i_mode)
				`UECM_M_NAK_INOUT, `UECM_M_NAK_OUT, `UECM_M_NAK_OUT_SI: o_resp = uecm_pkg::UECM_R_NAK;
				// RL19 check decided later
				`UECM_M_STAT_OUT, `UECM_M_NAK_IN_SO, `UECM_M_ACK_IN_SO: o_resp = uecm_pkg::UECM_R_CHECK;
				`UECM_M_STALL_IO, `UECM_M_STAT_IN: o_resp = uecm_pkg::UECM_R_STALL;
				`UECM_M_ISO_OUT, `UECM_M_ACK_OUT_SI: o_resp = uecm_pkg::UECM_R_ACK;
				// RL15 stall gates ack out
				// RL21 stall on non-control
				`UECM_M_ACK_OUT: o_resp = i_stall ? uecm_pkg::UECM_R_STALL : uecm_pkg::UECM_R_ACK;
				default: o_resp = uecm_pkg::UECM_R_IGNORE;
			endcase
		end
	end

	always_comb begin
		o_nxt_mode = i_mode;
		if (i_pid == uecm_pkg::UECM_PID_SETUP && setup_ok) begin
			// RL14 setup forces nak mode
			o_nxt_mode = `UECM_M_NAK_INOUT;
		end else if (i_acked) begin
			case (i_mode)
				// RL15 ack out to nak
				`UECM_M_ACK_OUT: o_nxt_mode = `UECM_M_NAK_OUT;
				// RL16 status in variant
				`UECM_M_ACK_OUT_SI: o_nxt_mode = `UECM_M_NAK_OUT_SI;
				// RL17 ack in to nak
				`UECM_M_ACK_IN: o_nxt_mode = `UECM_M_NAK_IN;
				// RL18 status out variant
				`UECM_M_ACK_IN_SO: o_nxt_mode = `UECM_M_NAK_IN_SO;
				default: o_nxt_mode = i_mode;
			endcase
		end
	end
endmodule : uecm_mode_decode
`default_nettype wire

/* File: verilog/uecm_endpoint_logic.sv */
// Operation
// RL1 - Firmware loads IN count, 0 to 32
// RL2 - OUT/SETUP count is bytes plus two
// RL3 - Valid flag only on good CRC receive
// RL4 - Bad CRC interrupts, valid flag cleared
// RL5 - Firmware sets toggle for IN packets
// RL6 - Received toggle copied into count register
// RL7 - Endpoint 0 count locked after receive update
// RL8 - Other count registers never locked
// RL9 - Setup bit held high until write ends
// RL10 - Only reads after update release lock
// RL11 - Update refreshes mode bits and count
// RL12 - Interrupt flag set at update point
// RL13 - Decode disable, status and stall modes
// RL14 - Nak mode forced by SETUP; isochronous modes
// RL15 - Ack out falls back to nak out
// RL16 - Ack out status in falls to nak
// RL17 - Ack in falls back to nak in
// RL18 - Ack in status out falls to nak
// RL19 - Check acks only zero-length DATA1 OUT
// RL20 - Endpoint 0 mode low bits locked
// RL21 - Stall bit acts in ack modes only
// RL22 - One lock flag per register gates writes
`timescale 1ns/1ps
`default_nettype none
`include "uecm_params.svh"
module uecm_endpoint_logic (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_b,
	input  wire logic [`UECM_ADDR_W-1:0]  i_io_addr,
	input  wire logic                     i_io_wr,
	input  wire logic                     i_io_rd,
	input  wire logic [`UECM_DATA_W-1:0]  i_io_wdata,
	output logic      [`UECM_DATA_W-1:0]  o_io_rdata,
	input  wire logic                     i_tok_vld,
	input  wire logic [1:0]               i_tok_pid,
	input  wire logic [`UECM_EP_W-1:0]    i_tok_ep,
	input  wire logic                     i_setup_pt,
	input  wire logic                     i_ctl_wr_end,
	input  wire logic                     i_upd,
	input  wire logic                     i_upd_crc_ok,
	input  wire logic [`UECM_CNT_W-1:0]   i_upd_rx_cnt,
	input  wire logic                     i_upd_rx_tog,
	input  wire logic                     i_upd_host_ack,
	output logic      [2:0]               o_tok_resp,
	output logic                          o_tok_resp_vld,
	output logic      [`UECM_CNT_W-1:0]   o_tx_cnt,
	output logic                          o_tx_tog,
	output logic      [2:0]               o_hs,
	output logic                          o_hs_vld,
	output logic      [`UECM_NUM_EP-1:0]  o_ep_irq,
	output logic                          o_ep0_mode_lock,
	output logic                          o_ep0_cnt_lock
);
	localparam logic [`UECM_ADDR_W-1:0] MODE_ADDR [`UECM_NUM_EP] = '{
		`UECM_ADDR_MODE0, `UECM_ADDR_MODE1, `UECM_ADDR_MODE2, `UECM_ADDR_MODE3, `UECM_ADDR_MODE4};
	localparam logic [`UECM_ADDR_W-1:0] CNT_ADDR [`UECM_NUM_EP] = '{
		`UECM_ADDR_CNT0, `UECM_ADDR_CNT1, `UECM_ADDR_CNT2, `UECM_ADDR_CNT3, `UECM_ADDR_CNT4};
	localparam logic [`UECM_EP_W-1:0] LAST_EP = 3'h4;

	logic                       rst_meta_b_ff;
	logic                       rst_b_ff;
	logic [`UECM_DATA_W-1:0]    mode_ff [`UECM_NUM_EP];
	logic [`UECM_DATA_W-1:0]    cnt_ff [`UECM_NUM_EP];
	logic [`UECM_NUM_EP-1:0]    hit_mode;
	logic [`UECM_NUM_EP-1:0]    hit_cnt;
	logic [`UECM_NUM_EP-1:0]    upd_ep;
	logic [`UECM_NUM_EP-1:0]    ep_irq_ff;
	uecm_pkg::uecm_state_t      st_ff;
	uecm_pkg::uecm_state_t      nxt_st;
	uecm_pkg::uecm_pid_t        tok_pid_ff;
	uecm_pkg::uecm_resp_t       tok_resp_ff;
	uecm_pkg::uecm_resp_t       tok_resp_dec;
	uecm_pkg::uecm_resp_t       upd_resp_unused;
	logic [`UECM_EP_W-1:0]      tok_ep_ff;
	logic [`UECM_DATA_W-1:0]    in_mode;
	logic [`UECM_DATA_W-1:0]    cur_mode;
	logic [3:0]                 nxt_mode_dec;
	logic [3:0]                 tok_nxt_unused;
	logic                       tok_ep_ok;
	logic                       upd_go;
	logic                       data_rx;
	logic                       acked;
	logic                       setup_hold_ff;
	logic [2:0]                 tok_resp_out_ff;
	logic                       tok_resp_vld_ff;
	logic [`UECM_CNT_W-1:0]     tx_cnt_ff;
	logic                       tx_tog_ff;
	logic [2:0]                 hs_ff;
	logic                       hs_vld_ff;
	logic [`UECM_DATA_W-1:0]    rdata_ff;
	logic [`UECM_DATA_W-1:0]    nxt_rdata;

	uecm_lock_if lk ();

	// Async assert, synchronous release
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_b_ff <= 1'b0;
			rst_b_ff      <= 1'b0;
		end else begin
			rst_meta_b_ff <= 1'b1;
			rst_b_ff      <= rst_meta_b_ff;
		end
	end

	assign tok_ep_ok = (i_tok_ep <= LAST_EP);
	assign in_mode   = tok_ep_ok ? mode_ff[i_tok_ep] : `UECM_MODE_RST;
	assign cur_mode  = mode_ff[tok_ep_ff];
	assign data_rx   = (tok_pid_ff != uecm_pkg::UECM_PID_IN);
	assign upd_go    = i_upd && (st_ff == uecm_pkg::UECM_ST_BUSY)
		&& (tok_resp_ff != uecm_pkg::UECM_R_IGNORE);

	// Response at token time, using the live mode of the addressed endpoint
	uecm_mode_decode u_dec_tok (
		.i_mode     (in_mode[3:0]),
		.i_stall    ((i_tok_ep != 3'h0) && in_mode[`UECM_MODE_STALL]),
		.i_pid      (uecm_pkg::uecm_pid_t'(i_tok_pid)),
		.i_acked    (1'b0),
		.o_resp     (tok_resp_dec),
		.o_nxt_mode (tok_nxt_unused)
	);

	// Mode change at the update point
	uecm_mode_decode u_dec_upd (
		.i_mode     (cur_mode[3:0]),
		.i_stall    ((tok_ep_ff != 3'h0) && cur_mode[`UECM_MODE_STALL]),
		.i_pid      (tok_pid_ff),
		.i_acked    (acked),
		.o_resp     (upd_resp_unused),
		.o_nxt_mode (nxt_mode_dec)
	);

	// RL19 zero-length DATA1 check
	always_comb begin
		acked = 1'b0;
		if (tok_pid_ff == uecm_pkg::UECM_PID_IN) begin
			acked = i_upd_host_ack && ((tok_resp_ff == uecm_pkg::UECM_R_TXCNT)
				|| (tok_resp_ff == uecm_pkg::UECM_R_TX0));
		end else if (tok_resp_ff == uecm_pkg::UECM_R_ACK) begin
			acked = i_upd_crc_ok;
		end else if (tok_resp_ff == uecm_pkg::UECM_R_CHECK) begin
			acked = i_upd_crc_ok && i_upd_rx_tog && (i_upd_rx_cnt == `UECM_RX_ZLP_CNT);
		end
	end

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			uecm_pkg::UECM_ST_IDLE: begin
				if (i_tok_vld && tok_ep_ok) begin
					nxt_st = uecm_pkg::UECM_ST_BUSY;
				end
			end
			uecm_pkg::UECM_ST_BUSY: begin
				if (i_upd) begin
					nxt_st = uecm_pkg::UECM_ST_IDLE;
				end
			end
			default: nxt_st = uecm_pkg::UECM_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			st_ff <= uecm_pkg::UECM_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// A new token restarts bookkeeping even if the last one never updated
	always_ff @(posedge i_clk or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			tok_pid_ff      <= uecm_pkg::UECM_PID_NONE;
			tok_ep_ff       <= 3'h0;
			tok_resp_ff     <= uecm_pkg::UECM_R_IGNORE;
			tok_resp_out_ff <= 3'h0;
			tok_resp_vld_ff <= 1'b0;
			tx_cnt_ff       <= 6'h00;
			tx_tog_ff       <= 1'b0;
		end else begin
			tok_resp_vld_ff <= i_tok_vld && tok_ep_ok;
			if (i_tok_vld && tok_ep_ok) begin
				tok_pid_ff      <= uecm_pkg::uecm_pid_t'(i_tok_pid);
				tok_ep_ff       <= i_tok_ep;
				tok_resp_ff     <= tok_resp_dec;
				tok_resp_out_ff <= tok_resp_dec;
				// RL1 firmware count sent
				tx_cnt_ff       <= cnt_ff[i_tok_ep][`UECM_CNT_W-1:0];
				// RL5 firmware toggle sent
				tx_tog_ff       <= cnt_ff[i_tok_ep][`UECM_CNT_TOG];
			end
		end
	end

	// Final handshake for OUT/SETUP; a failed check stalls
	always_ff @(posedge i_clk or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			hs_ff     <= 3'h0;
			hs_vld_ff <= 1'b0;
		end else begin
			hs_vld_ff <= upd_go && data_rx;
			if (upd_go && data_rx) begin
				if (acked) begin
					hs_ff <= uecm_pkg::UECM_R_ACK;
				end else if (tok_resp_ff == uecm_pkg::UECM_R_CHECK) begin
					hs_ff <= uecm_pkg::UECM_R_STALL;
				end else if (tok_resp_ff == uecm_pkg::UECM_R_ACK) begin
					hs_ff <= uecm_pkg::UECM_R_IGNORE;
				end else begin
					hs_ff <= tok_resp_ff;
				end
			end
		end
	end

	// RL9 setup bit hold window
	always_ff @(posedge i_clk or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			setup_hold_ff <= 1'b0;
		end else if (i_setup_pt && (tok_ep_ff == 3'h0)
			&& (tok_pid_ff == uecm_pkg::UECM_PID_SETUP)
			&& (tok_resp_ff == uecm_pkg::UECM_R_ACK)) begin
			setup_hold_ff <= 1'b1;
		end else if (i_ctl_wr_end) begin
			setup_hold_ff <= 1'b0;
		end
	end

	assign lk.mode_upd = upd_ep[0];
	// RL7 lock on receive update
	assign lk.cnt_upd  = upd_ep[0] && data_rx;
	assign lk.mode_rd  = i_io_rd && hit_mode[0];
	assign lk.cnt_rd   = i_io_rd && hit_cnt[0];

	uecm_ep0_lock u_lock (
		.i_clk   (i_clk),
		.i_rst_b (rst_b_ff),
		.lk      (lk.owner)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `UECM_NUM_EP; gi++) begin : g_ep
			assign hit_mode[gi] = (i_io_addr == MODE_ADDR[gi]);
			assign hit_cnt[gi]  = (i_io_addr == CNT_ADDR[gi]);
			assign upd_ep[gi]   = upd_go && (tok_ep_ff == gi[`UECM_EP_W-1:0]);

			// Hardware update sits after the CPU write so it wins a tie
			always_ff @(posedge i_clk or negedge rst_b_ff) begin
				if (!rst_b_ff) begin
					mode_ff[gi] <= `UECM_MODE_RST;
				end else begin
					if (i_io_wr && hit_mode[gi]) begin
						if (gi != 0) begin
							mode_ff[gi] <= i_io_wdata;
						end else begin
							// RL20 low bits write gate
							if (!lk.mode_lock) begin
								mode_ff[gi][`UECM_MODE_SETUP-1:0] <= i_io_wdata[`UECM_MODE_SETUP-1:0];
							end
							// RL9 clear blocked in hold
							if (!setup_hold_ff) begin
								mode_ff[gi][`UECM_MODE_SETUP] <= 1'b0;
							end
						end
					end
					if (gi == 0 && (setup_hold_ff || (i_setup_pt && tok_ep_ff == 3'h0
						&& tok_resp_ff == uecm_pkg::UECM_R_ACK
						&& tok_pid_ff == uecm_pkg::UECM_PID_SETUP))) begin
						mode_ff[gi][`UECM_MODE_SETUP] <= 1'b1;
					end
					// RL11 mode refresh
					if (upd_ep[gi]) begin
						mode_ff[gi][3:0] <= nxt_mode_dec;
						if (acked) begin
							mode_ff[gi][`UECM_MODE_ACK] <= 1'b1;
						end
						if (gi == 0 && tok_pid_ff == uecm_pkg::UECM_PID_IN) begin
							mode_ff[gi][`UECM_MODE_IN] <= 1'b1;
						end
						if (gi == 0 && tok_pid_ff == uecm_pkg::UECM_PID_OUT) begin
							mode_ff[gi][`UECM_MODE_OUT] <= 1'b1;
						end
					end
				end
			end

			always_ff @(posedge i_clk or negedge rst_b_ff) begin
				if (!rst_b_ff) begin
					cnt_ff[gi] <= `UECM_CNT_RST;
				end else if (upd_ep[gi] && data_rx) begin
					// RL2 received bytes plus CRC
					cnt_ff[gi][`UECM_CNT_W-1:0] <= i_upd_rx_cnt;
					// RL3 valid on good CRC
					// RL4 bad CRC clears valid
					cnt_ff[gi][`UECM_CNT_VALID] <= i_upd_crc_ok;
					// RL6 copy received toggle
					cnt_ff[gi][`UECM_CNT_TOG] <= i_upd_rx_tog;
				// RL8 only endpoint 0 gated
				// RL22 write gated by flag
				end else if (i_io_wr && hit_cnt[gi] && !(gi == 0 && lk.cnt_lock)) begin
					cnt_ff[gi] <= i_io_wdata;
				end
			end

			// RL12 interrupt at update
			always_ff @(posedge i_clk or negedge rst_b_ff) begin
				if (!rst_b_ff) begin
					ep_irq_ff[gi] <= 1'b0;
				end else begin
					ep_irq_ff[gi] <= upd_ep[gi] && (acked || (data_rx && !i_upd_crc_ok));
				end
			end
		end
	endgenerate

	// Unmapped addresses read zero
	always_comb begin
		nxt_rdata = 8'h00;
		for (int k = 0; k < `UECM_NUM_EP; k++) begin
			if (hit_mode[k]) begin
				nxt_rdata = mode_ff[k];
			end
			if (hit_cnt[k]) begin
				nxt_rdata = cnt_ff[k];
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			rdata_ff <= 8'h00;
		end else if (i_io_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_io_rdata      = rdata_ff;
	assign o_tok_resp      = tok_resp_out_ff;
	assign o_tok_resp_vld  = tok_resp_vld_ff;
	assign o_tx_cnt        = tx_cnt_ff;
	assign o_tx_tog        = tx_tog_ff;
	assign o_hs            = hs_ff;
	assign o_hs_vld        = hs_vld_ff;
	assign o_ep_irq        = ep_irq_ff;
	assign o_ep0_mode_lock = lk.mode_lock;
	assign o_ep0_cnt_lock  = lk.cnt_lock;
endmodule : uecm_endpoint_logic
`default_nettype wire

/* File: sim/uecm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uecm_host_model (
	input  wire logic  i_clk,
	output logic       o_tok_vld,
	output logic [1:0] o_pid,
	output logic [2:0] o_ep,
	output logic       o_setup_pt,
	output logic       o_wr_end,
	output logic       o_upd,
	output logic       o_crc_ok,
	output logic [5:0] o_cnt,
	output logic       o_tog,
	output logic       o_ack
);
	initial begin
		{o_tok_vld, o_pid, o_ep, o_setup_pt, o_wr_end, o_upd} = '0;
		{o_crc_ok, o_cnt, o_tog, o_ack} = '0;
	end

	// Released lines show the inverse, so stale values never pass
	task automatic token(input logic [1:0] pid, input logic [2:0] ep);
		@(negedge i_clk);
		o_tok_vld = 1'b1;
		o_pid = pid;
		o_ep = ep;
		@(negedge i_clk);
		o_tok_vld = 1'b0;
		o_pid = ~pid;
		o_ep = ~ep;
	endtask : token

	task automatic pulse(input logic is_end);
		@(negedge i_clk);
		o_setup_pt = !is_end;
		o_wr_end = is_end;
		@(negedge i_clk);
		o_setup_pt = 1'b0;
		o_wr_end = 1'b0;
	endtask : pulse

	task automatic finish(input logic ok, input logic [5:0] cnt, input logic tog, input logic ack);
		@(negedge i_clk);
		o_upd = 1'b1;
		o_crc_ok = ok;
		o_cnt = cnt;
		o_tog = tog;
		o_ack = ack;
		@(negedge i_clk);
		o_upd = 1'b0;
		o_crc_ok = !ok;
		o_cnt = ~cnt;
		o_tog = !tog;
		o_ack = !ack;
	endtask : finish
endmodule : uecm_host_model
`default_nettype wire

/* File: sim/uecm_endpoint_logic_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module uecm_endpoint_logic_monitor (
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_io_addr,
	input wire logic       i_io_rd,
	input wire logic       i_tok_vld,
	input wire logic [2:0] i_tok_ep,
	input wire logic       i_upd,
	input wire logic       o_tok_resp_vld,
	input wire logic       o_hs_vld,
	input wire logic [4:0] o_ep_irq,
	input wire logic       o_ep0_mode_lock,
	input wire logic       o_ep0_cnt_lock
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	AST_TOK_ANSWER: assert property (i_tok_vld && i_tok_ep <= 3'h4 |=> o_tok_resp_vld)
		else $error("token not answered");
	AST_RESP_CAUSE: assert property (o_tok_resp_vld |-> $past(i_tok_vld))
		else $error("response without token");
	AST_IRQ_AT_UPD: assert property (o_ep_irq != 5'h00 |-> $past(i_upd))
		else $error("interrupt away from update");
	AST_IRQ_PULSE: assert property (o_ep_irq != 5'h00 |=> o_ep_irq == 5'h00)
		else $error("interrupt longer than a cycle");
	AST_HS_AT_UPD: assert property (o_hs_vld |-> $past(i_upd))
		else $error("handshake away from update");
	AST_CNT_LOCK_SET: assert property ($rose(o_ep0_cnt_lock) |-> $past(i_upd))
		else $error("count lock set without update");
	AST_MODE_LOCK_SET: assert property ($rose(o_ep0_mode_lock) |-> $past(i_upd))
		else $error("mode lock set without update");
	AST_CNT_UNLOCK: assert property (o_ep0_cnt_lock && i_io_rd && i_io_addr == 8'h11 && !i_upd
		|=> !o_ep0_cnt_lock)
		else $error("count read did not unlock");
	AST_MODE_UNLOCK: assert property (o_ep0_mode_lock && i_io_rd && i_io_addr == 8'h12 && !i_upd
		|=> !o_ep0_mode_lock)
		else $error("mode read did not unlock");
	AST_CNT_HOLD: assert property (o_ep0_cnt_lock && !(i_io_rd && i_io_addr == 8'h11)
		|=> o_ep0_cnt_lock)
		else $error("count lock dropped without read");
	AST_MODE_HOLD: assert property (o_ep0_mode_lock && !(i_io_rd && i_io_addr == 8'h12)
		|=> o_ep0_mode_lock)
		else $error("mode lock dropped without read");
endmodule : uecm_endpoint_logic_monitor
`default_nettype wire

/* File: sim/tb_uecm_endpoint_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uecm_params.svh"
module tb_uecm_endpoint_logic;
	logic       i_clk;
	logic       i_rst_b;
	logic [7:0] io_addr, io_wdata, io_rdata;
	logic       io_wr, io_rd;
	wire        tok_vld, setup_pt, wr_end, upd, crc_ok, rx_tog, host_ack;
	wire  [1:0] tok_pid;
	wire  [2:0] tok_ep;
	wire  [5:0] rx_cnt;
	logic [2:0] tok_resp, hs;
	logic       tok_resp_vld, tx_tog, hs_vld, mode_lock, cnt_lock;
	logic [5:0] tx_cnt;
	logic [4:0] ep_irq;
	int         n_fail, checks_done;
	// Per mode {SETUP, IN, OUT} response codes
	localparam logic [11:0] RESP [16] = '{12'h000, 12'h122, 12'h136, 12'h133, 12'h100,
		12'h001, 12'h153, 12'h040, 12'h002, 12'h001, 12'h152, 12'h151, 12'h020, 12'h040,
		12'h126, 12'h146};
	localparam logic [7:0] REGS [10] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h41,
		8'h42, 8'h43, 8'h44};

	uecm_endpoint_logic dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_io_addr(io_addr),
		.i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
		.i_tok_vld(tok_vld), .i_tok_pid(tok_pid), .i_tok_ep(tok_ep), .i_setup_pt(setup_pt),
		.i_ctl_wr_end(wr_end), .i_upd(upd), .i_upd_crc_ok(crc_ok), .i_upd_rx_cnt(rx_cnt),
		.i_upd_rx_tog(rx_tog), .i_upd_host_ack(host_ack), .o_tok_resp(tok_resp),
		.o_tok_resp_vld(tok_resp_vld), .o_tx_cnt(tx_cnt), .o_tx_tog(tx_tog), .o_hs(hs),
		.o_hs_vld(hs_vld), .o_ep_irq(ep_irq), .o_ep0_mode_lock(mode_lock),
		.o_ep0_cnt_lock(cnt_lock));
	uecm_host_model host_u (.i_clk(i_clk), .o_tok_vld(tok_vld), .o_pid(tok_pid), .o_ep(tok_ep),
		.o_setup_pt(setup_pt), .o_wr_end(wr_end), .o_upd(upd), .o_crc_ok(crc_ok),
		.o_cnt(rx_cnt), .o_tog(rx_tog), .o_ack(host_ack));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge i_clk);
		io_wr = 1'b0;
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		@(negedge i_clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge i_clk);
		io_rd = 1'b0;
		chk(nm, {4'h0, io_rdata & m}, {4'h0, exp});
	endtask : rd

	task automatic tok(input logic [1:0] p, input logic [2:0] ep, input logic [2:0] exp);
		host_u.token(p, ep);
		chk("resp_vld", {11'h000, tok_resp_vld}, 12'h001);
		chk("tok_resp", {9'h000, tok_resp}, {9'h000, exp});
	endtask : tok

	task automatic test_done;
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		test_done();
	end

	initial begin
		{i_rst_b, io_addr, io_wdata, io_wr, io_rd} = '0;
		n_fail = 0;
		checks_done = 0;
		// Four rising edges pass with reset low
		repeat (4) @(negedge i_clk);
		i_rst_b = 1'b1;
		repeat (3) @(negedge i_clk);
		for (int i = 0; i < 10; i++) rd("reset", REGS[i], 8'hFF, 8'h00);
		rd("unmapped", 8'h20, 8'hFF, 8'h00);
		for (int m = 0; m < 16; m++) begin
			wr(`UECM_ADDR_MODE1, 8'(m));
			for (int p = 0; p < 3; p++) tok(2'(p), 3'h1, RESP[m][4*(2-p) +: 3]);
		end
		wr(`UECM_ADDR_MODE1, 8'h89);
		tok(2'h2, 3'h1, 3'h3);
		wr(`UECM_ADDR_MODE1, 8'h8D);
		tok(2'h1, 3'h1, 3'h3);
		wr(`UECM_ADDR_MODE1, 8'h09);
		tok(2'h2, 3'h1, 3'h1);
		host_u.finish(1'b1, 6'h0A, 1'b1, 1'b0);
		chk("irq out", {7'h00, ep_irq}, 12'h002);
		chk("hs out", {8'h00, hs_vld, hs}, 12'h009);
		rd("cnt1 out", `UECM_ADDR_CNT1, 8'hFF, 8'hCA);
		rd("mode1 out", `UECM_ADDR_MODE1, 8'h1F, 8'h18);
		wr(`UECM_ADDR_CNT1, 8'h05);
		rd("cnt1 write", `UECM_ADDR_CNT1, 8'hFF, 8'h05);
		wr(`UECM_ADDR_MODE1, 8'h09);
		tok(2'h2, 3'h1, 3'h1);
		host_u.finish(1'b0, 6'h0C, 1'b0, 1'b0);
		chk("irq crc", {7'h00, ep_irq}, 12'h002);
		rd("cnt1 crc", `UECM_ADDR_CNT1, 8'hFF, 8'h0C);
		// firmware IN load, 32 bytes DATA1
		wr(`UECM_ADDR_CNT1, 8'hA0);
		wr(`UECM_ADDR_MODE1, 8'h0D);
		tok(2'h1, 3'h1, 3'h4);
		chk("tx", {5'h00, tx_tog, tx_cnt}, 12'h060);
		host_u.finish(1'b1, 6'h00, 1'b0, 1'b1);
		chk("irq in", {7'h00, ep_irq}, 12'h002);
		rd("mode1 in", `UECM_ADDR_MODE1, 8'h1F, 8'h1C);
		wr(`UECM_ADDR_MODE0, 8'h02);
		tok(2'h0, 3'h0, 3'h1);
		host_u.pulse(1'b0);
		rd("setup set", `UECM_ADDR_MODE0, 8'h80, 8'h80);
		wr(`UECM_ADDR_MODE0, 8'h02);
		rd("setup held", `UECM_ADDR_MODE0, 8'h80, 8'h80);
		host_u.finish(1'b1, 6'h0A, 1'b0, 1'b0);
		chk("irq0", {7'h00, ep_irq}, 12'h001);
		chk("locks set", {10'h000, mode_lock, cnt_lock}, 12'h003);
		wr(`UECM_ADDR_CNT0, 8'h3F);
		wr(`UECM_ADDR_MODE0, 8'h05);
		rd("cnt0 locked", `UECM_ADDR_CNT0, 8'hFF, 8'h4A);
		rd("mode0 locked", `UECM_ADDR_MODE0, 8'hFF, 8'h91);
		chk("locks free", {10'h000, mode_lock, cnt_lock}, 12'h000);
		host_u.pulse(1'b1);
		wr(`UECM_ADDR_MODE0, 8'h05);
		wr(`UECM_ADDR_CNT0, 8'h20);
		rd("mode0 free", `UECM_ADDR_MODE0, 8'hFF, 8'h05);
		rd("cnt0 free", `UECM_ADDR_CNT0, 8'hFF, 8'h20);
		wr(`UECM_ADDR_MODE0, 8'h0F);
		tok(2'h2, 3'h0, 3'h6);
		host_u.finish(1'b1, 6'h02, 1'b1, 1'b0);
		chk("hs check", {8'h00, hs_vld, hs}, 12'h009);
		rd("mode0 check", `UECM_ADDR_MODE0, 8'hFF, 8'h3E);
		tok(2'h2, 3'h0, 3'h6);
		host_u.finish(1'b1, 6'h04, 1'b1, 1'b0);
		chk("hs bad check", {8'h00, hs_vld, hs}, 12'h00B);
		chk("irq bad check", {7'h00, ep_irq}, 12'h000);
		test_done();
	end
endmodule : tb_uecm_endpoint_logic

bind uecm_endpoint_logic uecm_endpoint_logic_monitor mon_u (.i_clk, .i_rst_b, .i_io_addr,
	.i_io_rd, .i_tok_vld, .i_tok_ep, .i_upd, .o_tok_resp_vld, .o_hs_vld, .o_ep_irq,
	.o_ep0_mode_lock, .o_ep0_cnt_lock);
`default_nettype wire
